// ---- usbmr_pkg.sv ----
// constants, types and register map of the usb multiport routing control
package usbmr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;  // usb_port_control_register
  localparam logic [7:0] REG_STAT  = 8'h04;  // routing and power status
  localparam logic [7:0] REG_DADDR = 8'h08;  // dma target address
  localparam logic [7:0] REG_DCNT  = 8'h0C;  // dma words still to move

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int CT_BYP_BIT  = 0;   // bypass request
  localparam int CT_DMA_BIT  = 1;   // dma enable
  localparam int CT_MODE_LSB = 4;   // two bits per port
  localparam int CT_HS_LSB   = 12;  // one high-speed enable per port
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int ST_BYP_BIT  = 0;   // bypass really active
  localparam int ST_SUSP_LSB = 1;   // transceiver suspended per port
  localparam int ST_STOP_LSB = 4;   // core clock stopped per port
  localparam int ST_BUSY_BIT = 7;   // dma engine busy
  localparam int ST_LVL_LSB  = 8;   // fifo fill level
  localparam logic [31:0] DADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DCNT_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // port modes, line rates, bus codes, timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PHY  = 2'h0;  // external serial transceiver
  localparam logic [1:0] MODE_ULPI = 2'h1;  // ulpi transceiver, port 2 only
  localparam logic [1:0] MODE_TLL  = 2'h2;  // transceiverless_link
  localparam int HS_RATE_KBPS = 480000;     // high-speed line rate
  localparam int FS_RATE_KBPS = 12000;      // full-speed line rate
  localparam int LS_RATE_KBPS = 1500;       // low-speed line rate
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
  localparam logic [3:0] LP_STOP_TICKS = 4'h3;  // 32 khz ticks before clock stop
  localparam int NPORT = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic oe;   // driver enabled
    logic se0;  // single-ended zero
    logic dat;  // differential data, 1 = j
  } usbmr_ser_t;
  localparam usbmr_ser_t SER_IDLE = '{oe: 1'b0, se0: 1'b0, dat: 1'b1};

  typedef enum logic [1:0] {PW_RUN, PW_SUSP, PW_STOP} usbmr_pwr_t;
  typedef enum logic [1:0] {DM_IDLE, DM_ADDR, DM_DATA} usbmr_dma_t;

endpackage

// ---- usbmr_top.sv ----
// port routing, transceiver modes, low power units, apb registers and dma
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// word fifo between core stream and dma master
// ----------------------------------------------------------------
module usbmr_fifo #(
  parameter int W  = 32,
  parameter int D  = 32,
  parameter int AW = $clog2(D)
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  output var  logic [W-1:0] out_data,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [AW:0]  level
);
  localparam logic [AW:0]   FULL = (AW+1)'(D);
  localparam logic [AW-1:0] LAST = AW'(D-1);
  logic [W-1:0]  mem_r [D];   // storage
  logic [AW-1:0] wp_r;        // write index
  logic [AW-1:0] rp_r;        // read index
  logic [AW:0]   cnt_r;       // words held
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;
  logic          notfull_r;   // registered ready toward source
  logic          nempty_r;    // registered valid toward sink

  assign push      = in_valid & notfull_r;
  assign pop       = nempty_r & out_ready;
  assign in_ready  = notfull_r;
  assign out_valid = nempty_r;
  assign out_data  = mem_r[rp_r];
  assign level     = cnt_r;

  // next fill count
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  // pointers, count and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
      notfull_r <= 1'b1;
      nempty_r  <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == LAST) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == LAST) ? '0 : rp_r + AW'(1);
      end
      cnt_r     <= cnt_nxt;
      notfull_r <= (cnt_nxt != FULL);
      nempty_r  <= (cnt_nxt != '0);
    end
  end

  // data store, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// top level
// ----------------------------------------------------------------
module usbmr_top import usbmr_pkg::*; #(
  parameter int FIFO_W = 32,
  parameter int FIFO_D = 32
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  output var  logic [31:0]       haddr,
  output var  logic [1:0]        htrans,
  output var  logic              hwrite,
  output var  logic [2:0]        hsize,
  output var  logic [31:0]       hwdata,
  input  wire logic              hready,
  input  wire logic [FIFO_W-1:0] strm_data,
  input  wire logic              strm_valid,
  output var  logic              strm_ready,
  input  wire usbmr_ser_t        core_tx [NPORT],
  output var  usbmr_ser_t        core_rx [NPORT],
  output var  usbmr_ser_t        port_tx [NPORT],
  input  wire usbmr_ser_t        port_rx [NPORT],
  output var  logic [1:0]        port_mode [NPORT],
  output var  logic [NPORT-1:0]  port_hs_en,
  input  wire logic              lp_clk,
  input  wire logic [NPORT-1:0]  core_susp_req,
  input  wire logic [NPORT-1:0]  core_wake,
  output var  logic [NPORT-1:0]  phy_susp,
  output var  logic [NPORT-1:0]  core_clk_stop
);
  localparam int LW = $clog2(FIFO_D) + 1;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]  ctrl_r;         // usb_port_control_register
  logic [31:0]  daddr_r;        // dma address
  logic [31:0]  dcnt_r;         // dma words left
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  logic         byp_act_r;      // bypass in force
  logic [1:0]   mode_r [NPORT]; // legal mode per port
  logic [NPORT-1:0] hs_r;
  usbmr_ser_t   ctx_r [NPORT];  // routed toward cores
  usbmr_ser_t   ptx_r [NPORT];  // routed toward pins
  usbmr_pwr_t   pw_r [NPORT];   // power unit states
  logic [3:0]   tk_r [NPORT];   // 32 khz ticks in suspend
  logic [NPORT-1:0] susp_r;
  logic [NPORT-1:0] stop_r;
  logic         lp_a_r;         // 32 khz sample chain
  logic         lp_b_r;
  logic         lp_c_r;
  logic         lp_tick;
  usbmr_dma_t   dm_r;
  logic [31:0]  haddr_r;
  logic [1:0]   htrans_r;
  logic [31:0]  hwdata_r;
  logic [31:0]  wdat_r;         // word taken from fifo
  logic         f_valid;
  logic         f_ready;
  logic [FIFO_W-1:0] f_data;
  logic [LW-1:0] f_level;
  logic         dm_go;
  logic         dm_done;
  logic         acc;            // apb access completing
  logic [31:0]  stat;

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign haddr         = haddr_r;
  assign htrans        = htrans_r;
  assign hwrite        = 1'b1;   // dma only writes received data out
  assign hsize         = HSIZE_WORD;
  assign hwdata        = hwdata_r;
  assign core_rx       = ctx_r;
  assign port_tx       = ptx_r;
  assign port_mode     = mode_r;
  assign port_hs_en    = hs_r;
  assign phy_susp      = susp_r;
  assign core_clk_stop = stop_r;

  // legal mode per port: otg serial only, port 1 no ulpi
  function automatic logic [1:0] legal(input int p, input logic [1:0] m);
    legal = MODE_PHY;
    if (m == MODE_TLL && p != 0) begin
      legal = MODE_TLL;
    end else if (m == MODE_ULPI && p == 2) begin
      legal = MODE_ULPI;
    end
  endfunction

  // ----------------------------------------------------------------
  // apb slave and register file
  // ----------------------------------------------------------------
  assign acc = psel & penable & pready_r;

  // status word assembled from live state
  always_comb begin
    stat = 32'h0000_0000;
    stat[ST_BYP_BIT]          = byp_act_r;
    stat[ST_SUSP_LSB +: NPORT] = susp_r;
    stat[ST_STOP_LSB +: NPORT] = stop_r;
    stat[ST_BUSY_BIT]         = (dm_r != DM_IDLE);
    stat[ST_LVL_LSB +: LW]    = f_level;
  end

  // no wait state: ready rises in the first access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r <= psel & ~penable & ~pready_r;
      if (psel && !penable) begin
        pslverr_r <= 1'b0;
        case (paddr)
          REG_CTRL:  prdata_r <= ctrl_r;
          REG_STAT:  prdata_r <= stat;
          REG_DADDR: prdata_r <= daddr_r;
          REG_DCNT:  prdata_r <= dcnt_r;
          default: begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b1;  // unmapped address
          end
        endcase
      end
    end
  end

  // software writes; dma advances address and count
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r  <= CTRL_RST;
      daddr_r <= DADDR_RST;
      dcnt_r  <= DCNT_RST;
    end else begin
      if (dm_done) begin
        daddr_r <= daddr_r + ADDR_STEP;
        dcnt_r  <= dcnt_r - 32'h0000_0001;
      end
      if (acc && pwrite) begin
        case (paddr)
          REG_CTRL:  ctrl_r  <= pwdata;
          REG_DADDR: daddr_r <= pwdata;
          REG_DCNT:  dcnt_r  <= pwdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // mode decode and bypass qualification
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      byp_act_r <= 1'b0;
      hs_r      <= '0;
      for (int p = 0; p < NPORT; p++) begin
        mode_r[p] <= MODE_PHY;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        mode_r[p] <= legal(p, ctrl_r[CT_MODE_LSB + 2*p +: 2]);
      end
      hs_r <= ctrl_r[CT_HS_LSB +: NPORT];
      // bypass follows the bit only with otg serial, port 1 link
      byp_act_r <= ctrl_r[CT_BYP_BIT] && mode_r[0] == MODE_PHY
                   && mode_r[1] == MODE_TLL;
    end
  end

  // ----------------------------------------------------------------
  // port routing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < NPORT; p++) begin
        ctx_r[p] <= SER_IDLE;
        ptx_r[p] <= SER_IDLE;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        ptx_r[p] <= core_tx[p];
        if (mode_r[p] == MODE_TLL && core_tx[p].oe) begin
          ctx_r[p] <= core_tx[p]; // own line echoed as a transceiver would
        end else begin
          ctx_r[p] <= port_rx[p];
        end
      end
      if (byp_act_r) begin
        ptx_r[0] <= port_rx[1];
        ptx_r[1] <= port_rx[0];
        ctx_r[0] <= SER_IDLE;
        ctx_r[1] <= SER_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // low power units on the 32 khz clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      lp_a_r <= 1'b0;
      lp_b_r <= 1'b0;
      lp_c_r <= 1'b0;
    end else begin
      lp_a_r <= lp_clk;
      lp_b_r <= lp_a_r;
      lp_c_r <= lp_b_r;
    end
  end
  assign lp_tick = lp_b_r & ~lp_c_r; // relies on a free-running slow clock

  for (genvar g = 0; g < NPORT; g++) begin : g_pw
    logic idle; // line at j with nobody driving
    assign idle = !port_rx[g].oe && !port_rx[g].se0 && port_rx[g].dat;
    // suspend when idle, stop core clock after some ticks
    always_ff @(posedge clk) begin
      if (rst) begin
        pw_r[g]   <= PW_RUN;
        tk_r[g]   <= 4'h0;
        susp_r[g] <= 1'b0;
        stop_r[g] <= 1'b0;
      end else begin
        case (pw_r[g])
          PW_RUN: begin
            tk_r[g] <= 4'h0;
            if (core_susp_req[g] && idle) begin
              pw_r[g]   <= PW_SUSP;
              susp_r[g] <= 1'b1;
            end
          end
          PW_SUSP, PW_STOP: begin
            if (core_wake[g] || !idle) begin
              pw_r[g]   <= PW_RUN;  // wake on resume or line activity
              susp_r[g] <= 1'b0;
              stop_r[g] <= 1'b0;
            end else if (pw_r[g] == PW_SUSP && lp_tick) begin
              tk_r[g] <= tk_r[g] + 4'h1;
              if (tk_r[g] == LP_STOP_TICKS - 4'h1) begin
                pw_r[g]   <= PW_STOP;
                stop_r[g] <= 1'b1;
              end
            end
          end
          default: pw_r[g] <= PW_RUN;
        endcase
      end
    end
    AST_STOP_SUSP: assert property (@(posedge clk) disable iff (rst)
      stop_r[g] |-> susp_r[g] && pw_r[g] == PW_STOP)
      else $error("clock stopped without transceiver suspend");
    AST_SUSP_IDLE: assert property (@(posedge clk) disable iff (rst)
      $rose(susp_r[g]) |-> $past(core_susp_req[g] && idle))
      else $error("suspend entered without request on idle bus");
  end

  // ----------------------------------------------------------------
  // fifo and ahb dma master
  // ----------------------------------------------------------------
  usbmr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (strm_data),
    .in_valid  (strm_valid),
    .in_ready  (strm_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .level     (f_level)
  );

  assign dm_go   = dm_r == DM_IDLE && ctrl_r[CT_DMA_BIT]
                   && dcnt_r != 32'h0000_0000 && f_valid;
  assign f_ready = dm_go;
  assign dm_done = dm_r == DM_DATA && hready;

  // single nonseq word writes, address then data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      dm_r     <= DM_IDLE;
      haddr_r  <= 32'h0000_0000;
      htrans_r <= HTRANS_IDLE;
      hwdata_r <= 32'h0000_0000;
      wdat_r   <= 32'h0000_0000;
    end else begin
      case (dm_r)
        DM_IDLE: begin
          if (dm_go) begin
            haddr_r  <= daddr_r;
            htrans_r <= HTRANS_NONSEQ;
            wdat_r   <= 32'(f_data);
            dm_r     <= DM_ADDR;
          end
        end
        DM_ADDR: begin
          if (hready) begin
            htrans_r <= HTRANS_IDLE;
            hwdata_r <= wdat_r;
            dm_r     <= DM_DATA;
          end
        end
        DM_DATA: begin
          if (hready) begin
            dm_r <= DM_IDLE;
          end
        end
        default: dm_r <= DM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_BYP_ROUTE: assert property (byp_act_r |=> ptx_r[0] == $past(port_rx[1])
    && ptx_r[1] == $past(port_rx[0]))
    else $error("bypass does not route otg transceiver to port 1");
  AST_BYP_DISC: assert property (byp_act_r |=> ctx_r[0] == SER_IDLE
    && ctx_r[1] == SER_IDLE)
    else $error("cores 0 and 1 still see lines in bypass");
  AST_NORM_ROUTE: assert property (!byp_act_r |=> ptx_r[0] == $past(core_tx[0])
    && ptx_r[1] == $past(core_tx[1]))
    else $error("cross routing outside bypass");
  AST_CORE2_OWN: assert property (##1 ptx_r[2] == $past(core_tx[2]))
    else $error("port 2 not driven by its own core");
  AST_BYP_LEGAL: assert property (byp_act_r |-> $past(mode_r[0]) == MODE_PHY
    && $past(mode_r[1]) == MODE_TLL)
    else $error("bypass active with illegal port modes");
  AST_BYP_FOLLOW: assert property (ctrl_r[CT_BYP_BIT] == 1'b0 |=> !byp_act_r)
    else $error("bypass stays after bit cleared");
  AST_RST_NORM: assert property (disable iff (1'b0) rst |=> !ctrl_r[CT_BYP_BIT]
    && !byp_act_r)
    else $error("bypass not clear after reset");
  AST_TLL_ECHO: assert property (mode_r[2] == MODE_TLL && core_tx[2].oe
    |=> ctx_r[2] == $past(core_tx[2]))
    else $error("link mode does not echo core drive");
  AST_APB_ONE: assert property (psel && !penable |=> pready_r ##1 !pready_r)
    else $error("apb ready not a single access cycle");
  AST_DMA_DATA: assert property ($rose(htrans_r == HTRANS_NONSEQ) |-> dm_r == DM_ADDR
    ##[1:1000] dm_r == DM_DATA && hwdata_r == $past(wdat_r))
    else $error("dma data phase missing");

  CV_BYPASS: cover property ($rose(byp_act_r));
  CV_STOP: cover property ($rose(stop_r[0]));
  CV_DMA: cover property (dm_done);
  CV_FULL: cover property (!strm_ready);
endmodule

`default_nettype wire

// ---- usbmr_xcvr_model.sv ----
// far-side model: transceivers and on-board peripherals on the ports
`timescale 1ns/10ps
`default_nettype none
module usbmr_xcvr_model import usbmr_pkg::*; (
  input  wire logic [NPORT-1:0] line_up,
  input  wire usbmr_ser_t       pat [NPORT],
  output var  usbmr_ser_t       port_rx [NPORT]
);
  // ----
  // line drive
  // ----
  // far side sends pat while active, else the pull-ups leave j idle
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      port_rx[i] = line_up[i] ? pat[i] : SER_IDLE;
    end
  end
endmodule
`default_nettype wire

// ---- usbmr_top_test.sv ----
// self-checking bench for the usb multiport routing control
`timescale 1ns/10ps
`default_nettype none
module usbmr_top_test import usbmr_pkg::*; ();
  // ----
  // signals
  // ----
  typedef struct {logic [31:0] d; logic e;} usbmr_note_t;
  logic clk = 1'b0, rst = 1'b1, lp_clk = 1'b0;        // clocks, reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;   // apb request
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, haddr, hwdata;
  logic pready, pslverr, hwrite, strm_ready;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hready = 1'b1, strm_valid = 1'b0, dph = 1'b0; // dph: data phase due
  logic [31:0] strm_data = 32'h0, eaddr = 32'h0;      // eaddr: next ahb address
  usbmr_ser_t core_tx [NPORT] = '{default: SER_IDLE};
  usbmr_ser_t pat [NPORT] = '{default: SER_IDLE};     // far-side line values
  usbmr_ser_t core_rx [NPORT], port_tx [NPORT], port_rx [NPORT];
  logic [1:0] port_mode [NPORT];
  logic [NPORT-1:0] port_hs_en, phy_susp, clk_stop;
  logic [NPORT-1:0] line_up = 3'h0, susp_req = 3'h0, wake = 3'h0;
  usbmr_note_t rdq [$];                               // expected read answers
  logic [31:0] wq [$];                                // expected ahb words
  int fails = 0, checked = 0;
  // ----
  // clocks and ahb slave stalls
  // ----
  always #2.5 clk = ~clk;
  always #15625 lp_clk = ~lp_clk; // runs through suspend
  always @(posedge clk) hready <= ($urandom_range(3) != 0);
  // ----
  // instances
  // ----
  usbmr_top #(.FIFO_W(32), .FIFO_D(32)) usbmr_top_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .strm_data(strm_data),
    .strm_valid(strm_valid), .strm_ready(strm_ready), .core_tx(core_tx),
    .core_rx(core_rx), .port_tx(port_tx), .port_rx(port_rx),
    .port_mode(port_mode), .port_hs_en(port_hs_en), .lp_clk(lp_clk),
    .core_susp_req(susp_req), .core_wake(wake), .phy_susp(phy_susp),
    .core_clk_stop(clk_stop));
  usbmr_xcvr_model usbmr_xcvr_model_i (
    .line_up(line_up), .pat(pat), .port_rx(port_rx));
  // ----
  // tasks
  // ----
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read with its expected answer noted first
  task automatic rd(logic [7:0] a, logic [31:0] e, logic err);
    rdq.push_back('{e, err});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // watchers
  // ----
  // apb answers against the oldest note
  always @(posedge clk) begin
    usbmr_note_t n;
    if (pready === 1'b1 && pwrite === 1'b0) begin
      n = rdq.pop_front();
      chk("prdata", prdata, n.d);
      chk("pslverr", 32'(pslverr), 32'(n.e));
    end
  end
  // ahb address and data phases against the pushed stream
  always @(posedge clk) begin
    if (hready === 1'b1) begin
      if (dph) chk("hwdata", hwdata, wq.pop_front());
      dph <= (htrans === HTRANS_NONSEQ);
      if (htrans === HTRANS_NONSEQ) begin
        chk("haddr", haddr, eaddr);
        chk("hsize", 32'({hwrite, hsize}), 32'({1'b1, HSIZE_WORD}));
        eaddr <= eaddr + ADDR_STEP;
      end
    end
  end
  // hang guard: the tests need about 80 us
  initial begin
    #400us;
    fails++;
    results();
  end
  // ----
  // tests
  // ----
  initial begin
    logic [31:0] v;
    logic [2:0] hs;
    int n;
    void'($urandom(32'h478C));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CTRL, CTRL_RST, 1'b0);
    rd(REG_STAT, 32'h0, 1'b0);
    rd(REG_DCNT, DCNT_RST, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    // each core owns its port, random traffic both ways
    for (int i = 0; i < NPORT; i++) begin
      core_tx[i] <= usbmr_ser_t'(3'($urandom));
      pat[i] <= usbmr_ser_t'(3'($urandom));
    end
    line_up <= 3'h7;
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < NPORT; i++) begin
      chk("port_tx", 32'(port_tx[i]), 32'(core_tx[i]));
      chk("core_rx", 32'(core_rx[i]), 32'(pat[i]));
    end
    // every mode on every port; illegal ones act as phy
    for (int m = 0; m < 3; m++) begin
      hs = 3'($urandom);
      v = {17'h0, hs, 2'h0, m[1:0], m[1:0], m[1:0], 4'h0};
      apb(1'b1, REG_CTRL, v);
      repeat (2) @(posedge clk);
      #1;
      chk("mode0", 32'(port_mode[0]), 32'(MODE_PHY));
      chk("mode1", 32'(port_mode[1]), (m == 1) ? 32'h0 : 32'(m));
      chk("mode2", 32'(port_mode[2]), 32'(m));
      chk("hs_en", 32'(port_hs_en), 32'(hs));
      rd(REG_CTRL, v, 1'b0);
    end
    // transceiverless link: core hears its own drive, else the line
    core_tx[2] <= '{oe: 1'b1, se0: 1'b0, dat: ~pat[2].dat};
    core_tx[1] <= '{oe: 1'b0, se0: 1'b1, dat: 1'b0};
    repeat (3) @(posedge clk);
    #1;
    chk("tll_own", 32'(core_rx[2]), 32'(core_tx[2]));
    chk("tll_far", 32'(core_rx[1]), 32'(pat[1]));
    // bypass: otg transceiver joined to port 1, both cores cut off
    apb(1'b1, REG_CTRL, 32'h81);
    repeat (4) @(posedge clk);
    #1;
    chk("byp_p1", 32'(port_tx[1]), 32'(pat[0]));
    chk("byp_p0", 32'(port_tx[0]), 32'(pat[1]));
    chk("byp_c0", 32'(core_rx[0]), 32'(SER_IDLE));
    chk("byp_c1", 32'(core_rx[1]), 32'(SER_IDLE));
    chk("byp_p2", 32'(port_tx[2]), 32'(core_tx[2]));
    rd(REG_STAT, 32'h1, 1'b0);
    // port 1 back to phy: bypass bit kept, routing normal again
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    #1;
    chk("nrm_p0", 32'(port_tx[0]), 32'(core_tx[0]));
    chk("nrm_p1", 32'(port_tx[1]), 32'(core_tx[1]));
    rd(REG_STAT, 32'h0, 1'b0);
    // idle port suspends, clock stops on slow ticks, then wake-ups
    line_up[2] <= 1'b0;
    susp_req[2] <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("susp", 32'(phy_susp), 32'h4);
    for (n = 0; n < 25000 && clk_stop !== 3'h4; n++) @(posedge clk);
    chk("stop", 32'(clk_stop), 32'h4);
    rd(REG_STAT, 32'h48, 1'b0);
    line_up[2] <= 1'b1;
    pat[2] <= '{oe: 1'b0, se0: 1'b1, dat: 1'b0}; // far side leaves idle for sure
    repeat (2) @(posedge clk);
    #1;
    chk("wake_ln", 32'({phy_susp, clk_stop}), 32'h0);
    @(posedge clk);
    line_up[2] <= 1'b0;
    repeat (3) @(posedge clk);
    wake[2] <= 1'b1;
    susp_req[2] <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("wake_cr", 32'({phy_susp, clk_stop}), 32'h0);
    @(posedge clk);
    wake[2] <= 1'b0;
    // fifo filled until it refuses, then drained by dma with stalls
    n = 0;
    strm_valid <= 1'b1;
    strm_data <= $urandom;
    repeat (40) begin
      @(posedge clk);
      if (strm_ready === 1'b1) begin
        wq.push_back(strm_data);
        n++;
      end
      strm_data <= $urandom;
    end
    strm_valid <= 1'b0;
    chk("filled", 32'(n), 32'h20);
    rd(REG_STAT, 32'h2000, 1'b0);
    eaddr = $urandom & 32'hFFFF_FF00;
    apb(1'b1, REG_DADDR, eaddr);
    apb(1'b1, REG_DCNT, 32'h20);
    apb(1'b1, REG_CTRL, 32'h2);
    for (n = 0; n < 2000 && wq.size() > 0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    rd(REG_DCNT, 32'h0, 1'b0);
    rd(REG_DADDR, eaddr, 1'b0);
    rd(REG_STAT, 32'h0, 1'b0);
    @(posedge clk);
    chk("left", 32'(rdq.size() + wq.size()), 32'h0);
    results();
  end
endmodule
`default_nettype wire
